//--- rtl/cim_alloc.sv
`default_nettype none
module cim_alloc
  import cim_pkg::*;
#(
  parameter int N_IDS = 8,
  parameter int IW = 3,
  parameter int TW = 16,
  parameter int ID_BASE = 11'h100
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic alloc_req_in,
  input wire logic rel_req_in,
  input wire logic [IW-1:0] rel_idx_in,
  input wire logic rel_timed_in,
  input wire logic [TW-1:0] rel_time_in,
  input wire logic epr_wr_in,
  input wire logic [IW-1:0] epr_idx_in,
  input wire logic [TW-1:0] epr_val_in,
  input wire logic rx_act_in,
  input wire logic [IW-1:0] rx_idx_in,
  input wire logic svc_req_in,
  input wire logic [7:0] svc_code_in,
  input wire logic [7:0] svc_class_in,
  input wire logic [7:0] svc_attr_in,
  output logic alloc_ack_out,
  output logic alloc_fail_out,
  output logic [10:0] conn_ident_out,
  output logic [IW-1:0] alloc_idx_out,
  output logic [N_IDS-1:0] timeout_out,
  output logic [N_IDS-1:0] free_map_out,
  output logic svc_ack_out,
  output logic svc_err_out,
  output logic [7:0] svc_errcode_out,
  output logic [15:0] svc_data_out
);
  import cim_pkg::*;
  logic [7:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 8'h01;
    if (tick_cnt_r == 8'(CIM_TICK_CYC - 1)) begin
      tick_cnt_nxt = 8'h00;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (ce_in) begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  cim_id_state_t st_r [N_IDS];
  cim_id_state_t st_nxt [N_IDS];
  logic [TW-1:0] epr_r [N_IDS];
  logic [TW-1:0] epr_nxt [N_IDS];
  logic [N_IDS-1:0] t_load, t_stop, t_run, t_exp;
  logic [TW-1:0] t_val [N_IDS];
  // Lowest free index, local allocation only
  logic found;
  logic [IW-1:0] pick;
  always_comb begin
    found = 1'b0;
    pick = '0;
    for (int i = N_IDS - 1; i >= 0; i--) begin
      if (st_r[i] == CIM_FREE) begin
        found = 1'b1;
        pick = IW'(i);
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < N_IDS; g++) begin : g_id
      logic rel_me, epr_me, rx_me, grab;
      always_comb begin
        rel_me = rel_req_in && (rel_idx_in == IW'(g)) && st_r[g] == CIM_USED;
        epr_me = epr_wr_in && (epr_idx_in == IW'(g)) && st_r[g] == CIM_USED;
        rx_me = rx_act_in && (rx_idx_in == IW'(g)) && st_r[g] == CIM_USED;
        grab = alloc_req_in && found && (pick == IW'(g));
        st_nxt[g] = st_r[g];
        epr_nxt[g] = epr_r[g];
        t_load[g] = 1'b0;
        t_stop[g] = 1'b0;
        t_val[g] = epr_r[g];
        case (st_r[g])
          CIM_FREE: begin
            if (grab) begin
              st_nxt[g] = CIM_USED;
              t_stop[g] = 1'b1;
            end
          end
          CIM_USED: begin
            if (rel_me) begin
              if (rel_timed_in) begin
                st_nxt[g] = CIM_DRAIN;
                t_load[g] = 1'b1;
                t_val[g] = rel_time_in;
              end else begin
                st_nxt[g] = CIM_FREE;
                t_stop[g] = 1'b1;
              end
            end else if (epr_me) begin
              epr_nxt[g] = epr_val_in;
              t_load[g] = 1'b1;
              t_val[g] = epr_val_in;
            end else if (rx_me && epr_r[g] != '0) begin
              t_load[g] = 1'b1;
            end
          end
          CIM_DRAIN: begin
            if (t_exp[g]) begin
              st_nxt[g] = CIM_FREE;
            end
          end
          default: st_nxt[g] = CIM_FREE;
        endcase
      end
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          st_r[g] <= CIM_FREE;
          epr_r[g] <= '0;
        end else if (ce_in) begin
          st_r[g] <= st_nxt[g];
          epr_r[g] <= epr_nxt[g];
        end
      end
      cim_timer #(.W(TW)) u_tmr (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .en_in(ce_in),
        .tick_in(tick_r),
        .load_in(t_load[g]),
        .stop_in(t_stop[g]),
        .val_in(t_val[g]),
        .run_out(t_run[g]),
        .exp_out(t_exp[g])
      );
    end
  endgenerate
  // Outputs registered; one service engine for the single attachment
  logic alloc_ack_r, alloc_fail_r, svc_ack_r, svc_err_r;
  logic [10:0] cid_r;
  logic [IW-1:0] aidx_r;
  logic [N_IDS-1:0] tmo_r, free_r, tmo_nxt, free_nxt;
  logic [7:0] ecode_r, ecode_nxt;
  logic [15:0] sdata_r, sdata_nxt;
  logic serr_nxt;
  always_comb begin
    for (int i = 0; i < N_IDS; i++) begin
      tmo_nxt[i] = (st_r[i] == CIM_USED) && t_exp[i];
      free_nxt[i] = (st_nxt[i] == CIM_FREE);
    end
    serr_nxt = 1'b0;
    ecode_nxt = 8'h00;
    sdata_nxt = 16'h0000;
    if (svc_class_in != CIM_CLASS_CODE) begin
      serr_nxt = 1'b1;
      ecode_nxt = CIM_ERR_NO_CLASS;
    end else if (svc_code_in != CIM_SVC_GET_SINGLE) begin
      serr_nxt = 1'b1;
      ecode_nxt = CIM_ERR_NO_SVC;
    end else if (svc_attr_in != CIM_ATTR_REV) begin
      serr_nxt = 1'b1;
      ecode_nxt = CIM_ERR_NO_ATTR;
    end else begin
      sdata_nxt = CIM_REVISION;
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      alloc_ack_r <= 1'b0;
      alloc_fail_r <= 1'b0;
      cid_r <= 11'h000;
      aidx_r <= '0;
      tmo_r <= '0;
      free_r <= '1;
      svc_ack_r <= 1'b0;
      svc_err_r <= 1'b0;
      ecode_r <= 8'h00;
      sdata_r <= 16'h0000;
    end else if (ce_in) begin
      alloc_ack_r <= alloc_req_in && found;
      alloc_fail_r <= alloc_req_in && !found;
      if (alloc_req_in && found) begin
        // Own base plus index; bases differ per node
        cid_r <= 11'(ID_BASE) + 11'(pick);
        aidx_r <= pick;
      end
      tmo_r <= tmo_nxt;
      free_r <= free_nxt;
      svc_ack_r <= svc_req_in;
      if (svc_req_in) begin
        svc_err_r <= serr_nxt;
        ecode_r <= ecode_nxt;
        sdata_r <= sdata_nxt;
      end
    end
  end
  assign alloc_ack_out = alloc_ack_r;
  assign alloc_fail_out = alloc_fail_r;
  assign conn_ident_out = cid_r;
  assign alloc_idx_out = aidx_r;
  assign timeout_out = tmo_r;
  assign free_map_out = free_r;
  assign svc_ack_out = svc_ack_r;
  assign svc_err_out = svc_err_r;
  assign svc_errcode_out = ecode_r;
  assign svc_data_out = sdata_r;

  drain_hold_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && st_r[0] == CIM_DRAIN && !t_exp[0] |=> st_r[0] != CIM_FREE)
    else $error("drained id freed early");
  drain_free_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && st_r[0] == CIM_DRAIN && t_exp[0] |=> st_r[0] == CIM_FREE)
    else $error("expired id not freed");
  // Timed release of index 0 taken this cycle
  sequence rel_timed0_s;
    ce_in && rel_req_in && rel_timed_in && rel_idx_in == '0
    && st_r[0] == CIM_USED;
  endsequence
  drain_enter_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    rel_timed0_s |=> st_r[0] == CIM_DRAIN && !free_r[0])
    else $error("timed release not draining");
  untimed_free_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && rel_req_in && !rel_timed_in && rel_idx_in == '0
    && st_r[0] == CIM_USED |=> st_r[0] == CIM_FREE)
    else $error("untimed release not immediate");
  epr_restart_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && epr_wr_in && epr_idx_in == '0 && st_r[0] == CIM_USED
    && !rel_req_in && epr_val_in != '0 |=> t_run[0])
    else $error("timer not restarted");
  free_map_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in |=> free_r[0] == (st_r[0] == CIM_FREE))
    else $error("free map mismatch");
  no_double_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && alloc_req_in && found |=> st_r[$past(pick)] == CIM_USED)
    else $error("alloc state wrong");
  alloc_id_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && alloc_req_in && found |=>
    alloc_ack_r && cid_r == 11'(ID_BASE) + 11'($past(pick)))
    else $error("bad identifier");
  alloc_local_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && alloc_req_in && !found |=> alloc_fail_r && !alloc_ack_r)
    else $error("fail not reported");
  rev_read_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && svc_req_in && svc_class_in == CIM_CLASS_CODE
    && svc_code_in == CIM_SVC_GET_SINGLE && svc_attr_in == CIM_ATTR_REV
    |=> svc_ack_r && !svc_err_r && sdata_r == CIM_REVISION)
    else $error("revision read wrong");
  class_err_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && svc_req_in && svc_class_in != CIM_CLASS_CODE
    |=> svc_err_r && ecode_r == CIM_ERR_NO_CLASS)
    else $error("class not checked");
  svc_err_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && svc_req_in && svc_class_in == CIM_CLASS_CODE
    && svc_code_in != CIM_SVC_GET_SINGLE |=> svc_err_r)
    else $error("service not checked");
  one_obj_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in |=> svc_ack_r == $past(svc_req_in))
    else $error("service ack wrong");
endmodule : cim_alloc
`default_nettype wire

//--- rtl/cim_pkg.sv
// Contract
// - Expected-interval change in established state restarts inactivity timer from new value.
// - Each end-point runs its own local identifier allocation for dynamic connections.
// - Identifiers no longer used by any connection return to the free pool.
// - Allocation never lets two nodes transmit the same identifier bit pattern.
// - Released identifier is reused only after all connection end-points timed out; an untimed release frees it for reuse at once.
// - Timed connection release starts fresh reclaim timer; free only on its expiry.
// - Untimed connection release may free the identifier immediately.
// - Exactly one network-attachment object per physical attachment.
// - Network-attachment object class is addressed by class code 3.
// - Class attribute 1 is read-only 16-bit object revision.
// - Single-attribute read service returns requested class attribute value.
`default_nettype none
package cim_pkg;
  localparam logic [7:0] CIM_CLASS_CODE = 8'h03;
  localparam logic [7:0] CIM_ATTR_REV = 8'h01;
  localparam logic [7:0] CIM_SVC_GET_SINGLE = 8'h0E;
  localparam logic [7:0] CIM_ERR_NO_ATTR = 8'h14;
  localparam logic [7:0] CIM_ERR_NO_SVC = 8'h08;
  localparam logic [7:0] CIM_ERR_NO_CLASS = 8'h16;
  // Revision is an arbitrary default
  localparam logic [15:0] CIM_REVISION = 16'h0002;
  localparam int CIM_TICK_NS = 1000;
  localparam int CIM_CLK_NS = 25;
  localparam int CIM_TICK_CYC = (CIM_TICK_NS + CIM_CLK_NS - 1) / CIM_CLK_NS;
  typedef enum logic [2:0] {
    CIM_FREE = 3'b001,
    CIM_USED = 3'b010,
    CIM_DRAIN = 3'b100
  } cim_id_state_t;
endpackage : cim_pkg
`default_nettype wire

//--- rtl/cim_timer.sv
`default_nettype none
module cim_timer #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic en_in,
  input wire logic tick_in,
  input wire logic load_in,
  input wire logic stop_in,
  input wire logic [W-1:0] val_in,
  output logic run_out,
  output logic exp_out
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt, exp_r, exp_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    exp_nxt = 1'b0;
    if (load_in) begin
      // Cancel and reload in one step
      cnt_nxt = val_in;
      run_nxt = (val_in != '0);
      exp_nxt = (val_in == '0);
    end else if (stop_in) begin
      run_nxt = 1'b0;
    end else if (run_r && tick_in) begin
      if (cnt_r <= W'(1)) begin
        run_nxt = 1'b0;
        exp_nxt = 1'b1;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else if (en_in) begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      exp_r <= exp_nxt;
    end
  end
  assign run_out = run_r;
  assign exp_out = exp_r;
endmodule : cim_timer
`default_nettype wire

//--- verif/cim_peer.sv
`default_nettype none
module cim_peer #(
  parameter int PER = 20
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic run_in,
  input wire logic [2:0] idx_in,
  output logic rx_act_out,
  output logic [2:0] rx_idx_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  // Peer sends activity on idx_in, which the testbench ties to our index 0
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt = 0;
      rx_act_out <= 1'b0;
      rx_idx_out <= 3'h0;
    end else begin
      cnt = (run_in && cnt < PER - 1) ? cnt + 1 : 0;
      rx_act_out <= #2 run_in && cnt == 0;
      // Idle index wanders so a stale value is never trusted
      rx_idx_out <= #2 (run_in && cnt == 0) ? idx_in : ~rx_idx_out;
    end
  end
endmodule : cim_peer
`default_nettype wire

//--- verif/tb.sv
`default_nettype none
module tb import cim_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, nrst_in, alloc_req_in, rel_req_in, rel_timed_in, epr_wr_in;
  logic svc_req_in, peer_run, rx_act, alloc_ack_out, alloc_fail_out;
  logic svc_ack_out, svc_err_out, ce_in;
  logic [2:0] rel_idx_in, epr_idx_in, rx_idx, alloc_idx_out;
  logic [15:0] rel_time_in, epr_val_in, svc_data_out;
  logic [7:0] svc_code_in, svc_class_in, svc_attr_in, svc_errcode_out;
  logic [7:0] timeout_out, free_map_out;
  logic [10:0] conn_ident_out;
  int err_total = 0;
  int comparisons = 0;
  localparam logic [7:0] T_CLS [4] = '{CIM_CLASS_CODE, 8'h04, 8'h03, 8'h03};
  localparam logic [7:0] T_SVC [4] = '{8'h0E, 8'h0E, 8'h10, 8'h0E};
  localparam logic [7:0] T_ATR [4] = '{8'h01, 8'h01, 8'h01, 8'h02};
  localparam logic [7:0] T_ERR [4] = '{8'h00, 8'h16, 8'h08, 8'h14};

  cim_alloc cim_alloc_i (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .alloc_req_in(alloc_req_in), .rel_req_in(rel_req_in),
    .rel_idx_in(rel_idx_in), .rel_timed_in(rel_timed_in),
    .rel_time_in(rel_time_in), .epr_wr_in(epr_wr_in),
    .epr_idx_in(epr_idx_in), .epr_val_in(epr_val_in),
    .rx_act_in(rx_act), .rx_idx_in(rx_idx), .svc_req_in(svc_req_in),
    .svc_code_in(svc_code_in), .svc_class_in(svc_class_in),
    .svc_attr_in(svc_attr_in), .alloc_ack_out(alloc_ack_out),
    .alloc_fail_out(alloc_fail_out), .conn_ident_out(conn_ident_out),
    .alloc_idx_out(alloc_idx_out), .timeout_out(timeout_out),
    .free_map_out(free_map_out), .svc_ack_out(svc_ack_out),
    .svc_err_out(svc_err_out), .svc_errcode_out(svc_errcode_out),
    .svc_data_out(svc_data_out));
  cim_peer cim_peer_i (.clk_in(clk_in), .nrst_in(nrst_in),
    .run_in(peer_run), .idx_in(3'h0), .rx_act_out(rx_act),
    .rx_idx_out(rx_idx));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : step

  task chk_v(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v

  task wait_ack(input bit svc);
    for (int n = 0; n < 4; n++) begin
      if (svc ? svc_ack_out === 1'b1 :
          (alloc_ack_out | alloc_fail_out) === 1'b1) break;
      step(1);
    end
  endtask : wait_ack

  task do_alloc;
    // Idle edge so a lowered request is never raised in the same step
    step(1);
    alloc_req_in = 1'b1;
    step(1);
    alloc_req_in = 1'b0;
    wait_ack(1'b0);
  endtask : do_alloc

  task t_alloc_all;
    chk_v(16'(free_map_out), 16'h00FF);
    for (int i = 0; i < 8; i++) begin
      do_alloc();
      chk_v(16'(alloc_ack_out), 16'h0001);
      chk_v(16'(conn_ident_out), 16'(11'h100 + i));
      chk_v(16'(free_map_out), 16'(8'(8'hFF << (i + 1))));
    end
    do_alloc();
    chk_v(16'(alloc_fail_out), 16'h0001);
  endtask : t_alloc_all

  task t_release_now;
    rel_req_in = 1'b1;
    rel_idx_in = 3'h0;
    rel_timed_in = 1'b0;
    step(1);
    rel_req_in = 1'b0;
    chk_v(16'(free_map_out), 16'h0001);
    do_alloc();
    chk_v(16'(alloc_idx_out), 16'h0000);
    chk_v(16'(conn_ident_out), 16'h0100);
  endtask : t_release_now

  task t_release_timed;
    int n;
    rel_req_in = 1'b1;
    rel_idx_in = 3'h0;
    rel_timed_in = 1'b1;
    rel_time_in = 16'h0003;
    step(1);
    rel_req_in = 1'b0;
    step(78);
    chk_v(16'(free_map_out[0]), 16'h0000);
    for (n = 0; n < 170 && free_map_out[0] !== 1'b1; n++) step(1);
    chk_v(16'(free_map_out[0]), 16'h0001);
    // Three ticks of unknown phase, then one edge to free
    chk_v(16'(n >= 4 && n <= 43), 16'h0001);
    do_alloc();
    chk_v(16'(alloc_idx_out), 16'h0000);
    chk_v(16'(conn_ident_out), 16'h0100);
  endtask : t_release_timed

  task t_interval;
    int n;
    int hits;
    hits = 0;
    epr_wr_in = 1'b1;
    epr_idx_in = 3'h0;
    epr_val_in = 16'h000A;
    step(1);
    epr_wr_in = 1'b0;
    peer_run = 1'b1;
    for (n = 0; n < 500; n++) begin
      step(1);
      hits += int'(timeout_out[0] === 1'b1);
    end
    chk_v(16'(hits), 16'h0000);
    peer_run = 1'b0;
    step(100);
    // Shorter interval must fire well before the old one would
    epr_wr_in = 1'b1;
    epr_val_in = 16'h0002;
    step(1);
    epr_wr_in = 1'b0;
    for (n = 0; n < 200 && timeout_out[0] !== 1'b1; n++) step(1);
    chk_v(16'(n >= 42 && n <= 81), 16'h0001);
  endtask : t_interval

  task t_service;
    for (int i = 0; i < 4; i++) begin
      step(1);
      svc_req_in = 1'b1;
      svc_class_in = T_CLS[i];
      svc_code_in = T_SVC[i];
      svc_attr_in = T_ATR[i];
      step(1);
      svc_req_in = 1'b0;
      wait_ack(1'b1);
      chk_v(16'(svc_ack_out), 16'h0001);
      chk_v(16'(svc_err_out), 16'(i != 0));
      if (i == 0) chk_v(svc_data_out, CIM_REVISION);
      else chk_v(16'(svc_errcode_out), 16'(T_ERR[i]));
    end
    // Enable low must swallow a request and freeze the ack
    step(1);
    ce_in = 1'b0;
    svc_req_in = 1'b1;
    step(2);
    chk_v(16'(svc_ack_out), 16'h0000);
    svc_req_in = 1'b0;
    ce_in = 1'b1;
    step(1);
    chk_v(16'(svc_ack_out), 16'h0000);
  endtask : t_service

  task give_verdict;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  initial begin
    #200_000;
    err_total++;
    give_verdict();
  end

  initial begin
    {nrst_in, alloc_req_in, rel_req_in, rel_timed_in, epr_wr_in} = '0;
    {svc_req_in, peer_run, rel_idx_in, epr_idx_in} = '0;
    {rel_time_in, epr_val_in, svc_code_in, svc_class_in, svc_attr_in} = '0;
    ce_in = 1'b1;
    step(16);
    nrst_in = 1'b1;
    t_alloc_all();
    t_release_now();
    t_release_timed();
    t_interval();
    t_service();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
